// File: src/gpe_top.sv
// Operation
// - polarity bit 0 clear inverts shared event level
// - polarity 0 active low, 1 active high
// - enabled port's notifications diverted to shared event
// - shared event is gpio 7 alternate function
// - gpio 7 carries event only in alternate mode
// - status bit set while port drives event
// - status never set while port enable clear in the previous cycle
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"

module gpe_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`GPE_ADDR_W-1:0] paddr,
    input wire logic [`GPE_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`GPE_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:1] port_req_hotplug,
    input wire logic [3:1] port_req_msi,
    input wire logic [3:1] port_req_pme,
    output logic [3:1] port_pass_hotplug,
    output logic [3:1] port_pass_msi,
    output logic [3:1] port_pass_pme,
    input wire logic gpio7_alt_en,
    input wire logic gpio7_gen_out,
    input wire logic gpio7_gen_oe,
    output logic gpio7_out,
    output logic gpio7_oe,
    output logic shared_event_out,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    gpe_pkg::gpe_reg_e reg_sel;
    logic access_d;
    logic wr_en;
    logic rd_setup;
    logic wr_byte0;
    logic wr_control;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic bad_addr;
    logic bad_write;

    logic event_polarity_invert_q;
    gpe_pkg::gpe_port_vec_t port_event_divert_en_q;

    gpe_pkg::gpe_port_vec_t port_active;
    gpe_pkg::gpe_port_vec_t port_event_active_q;
    gpe_pkg::gpe_port_vec_t pass_hp;
    gpe_pkg::gpe_port_vec_t pass_msi;
    gpe_pkg::gpe_port_vec_t pass_pme;
    logic [3*`GPE_SRC_W-1:0] source_d;
    logic [3*`GPE_SRC_W-1:0] source_q;

    logic any_event;
    logic event_level;

    gpe_pkg::gpe_port_vec_t irq_status_q;
    gpe_pkg::gpe_port_vec_t irq_mask_q;
    gpe_pkg::gpe_port_vec_t irq_rise;
    gpe_pkg::gpe_port_vec_t irq_clear;
    gpe_pkg::gpe_port_vec_t irq_status_d;

    logic [`GPE_DATA_W-1:0] rdata_d;
    logic [`GPE_DATA_W-1:0] prdata_q;
    logic pslverr_q;
    logic gpio7_out_d;
    logic gpio7_oe_d;
    logic gpio7_out_q;
    logic gpio7_oe_q;
    logic shared_event_q;
    logic irq_q;
    gpe_pkg::gpe_port_vec_t pass_hp_q;
    gpe_pkg::gpe_port_vec_t pass_msi_q;
    gpe_pkg::gpe_port_vec_t pass_pme_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    always_comb begin
        case (paddr)
            `GPE_OFS_CONTROL: begin
                reg_sel = gpe_pkg::GPE_REG_CONTROL;
            end
            `GPE_OFS_STATUS: begin
                reg_sel = gpe_pkg::GPE_REG_STATUS;
            end
            `GPE_OFS_IRQ_STATUS: begin
                reg_sel = gpe_pkg::GPE_REG_IRQ_STATUS;
            end
            `GPE_OFS_IRQ_MASK: begin
                reg_sel = gpe_pkg::GPE_REG_IRQ_MASK;
            end
            `GPE_OFS_SOURCE: begin
                reg_sel = gpe_pkg::GPE_REG_SOURCE;
            end
            default: begin
                reg_sel = gpe_pkg::GPE_REG_NONE;
            end
        endcase
    end

    // answer comes in the first access cycle, read data prepared in setup
    assign access_d = psel & penable;
    assign pready = access_d;
    assign rd_setup = psel & ~penable;
    assign wr_en = access_d & pwrite;
    assign wr_byte0 = pstrb[0];

    // register write strobes, every writable field sits in byte 0
    assign wr_control = wr_en & wr_byte0 & (reg_sel == gpe_pkg::GPE_REG_CONTROL);
    assign wr_irq_status = wr_en & wr_byte0 & (reg_sel == gpe_pkg::GPE_REG_IRQ_STATUS);
    assign wr_irq_mask = wr_en & wr_byte0 & (reg_sel == gpe_pkg::GPE_REG_IRQ_MASK);

    // unmapped address, or a write to a read-only register
    assign bad_addr = (reg_sel == gpe_pkg::GPE_REG_NONE);
    assign bad_write = pwrite & ((reg_sel == gpe_pkg::GPE_REG_STATUS)
        | (reg_sel == gpe_pkg::GPE_REG_SOURCE));

    ////////////////////////////////////////////////////////////////////////////
    // event_control

    // polarity of the shared event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_polarity_invert_q <= `GPE_RST_POL_INVERT;
        end else if (wr_control) begin
            event_polarity_invert_q <= pwdata[`GPE_BIT_POL_INVERT];
        end
    end

    // per-port divert enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_event_divert_en_q <= `GPE_RST_DIVERT_EN;
        end else if (wr_control) begin
            port_event_divert_en_q <= pwdata[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port steering

    genvar gi;
    generate
        for (gi = 1; gi <= 3; gi++) begin : g_port
            gpe_port_event u_port (
                .divert_en(port_event_divert_en_q[gi]),
                .req_hotplug(port_req_hotplug[gi]),
                .req_msi(port_req_msi[gi]),
                .req_pme(port_req_pme[gi]),
                .active(port_active[gi]),
                .pass_hotplug(pass_hp[gi]),
                .pass_msi(pass_msi[gi]),
                .pass_pme(pass_pme[gi]),
                .source(source_d[(gi-1)*`GPE_SRC_W +: `GPE_SRC_W])
            );
        end
    endgenerate

    // event_status follows the ports that drive the shared event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_event_active_q <= `GPE_RST_STATUS;
        end else begin
            port_event_active_q <= port_active;
        end
    end

    // kinds of notification behind each diverted event, for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_q <= `GPE_RST_SOURCE;
        end else begin
            source_q <= source_d;
        end
    end

    // native notification paths, closed for diverted ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_hp_q <= 3'h0;
            pass_msi_q <= 3'h0;
            pass_pme_q <= 3'h0;
        end else begin
            pass_hp_q <= pass_hp;
            pass_msi_q <= pass_msi;
            pass_pme_q <= pass_pme;
        end
    end

    assign port_pass_hotplug = pass_hp_q;
    assign port_pass_msi = pass_msi_q;
    assign port_pass_pme = pass_pme_q;

    ////////////////////////////////////////////////////////////////////////////
    // shared event and gpio 7

    // ports are or-ed before the polarity is applied
    assign any_event = |port_active;
    assign event_level = event_polarity_invert_q ? any_event : ~any_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle level, so reset never shows a false event
            shared_event_q <= `GPE_RST_EVENT;
        end else begin
            shared_event_q <= event_level;
        end
    end

    assign shared_event_out = shared_event_q;

    // pin 7 carries the event only in its alternate function
    always_comb begin
        if (gpio7_alt_en) begin
            gpio7_out_d = event_level;
            gpio7_oe_d = 1'b1;
        end else begin
            gpio7_out_d = gpio7_gen_out;
            gpio7_oe_d = gpio7_gen_oe;
        end
    end

    // reset leaves pin 7 undriven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio7_out_q <= 1'b0;
            gpio7_oe_q <= 1'b0;
        end else begin
            gpio7_out_q <= gpio7_out_d;
            gpio7_oe_q <= gpio7_oe_d;
        end
    end

    assign gpio7_out = gpio7_out_q;
    assign gpio7_oe = gpio7_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    // a status bit rises with the port's event_status bit
    assign irq_rise = port_active & ~port_event_active_q;
    assign irq_clear = wr_irq_status ? pwdata[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO] : 3'h0;

    // a new event in the clearing cycle wins
    assign irq_status_d = (irq_status_q & ~irq_clear) | irq_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= `GPE_RST_IRQ_STATUS;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= `GPE_RST_IRQ_MASK;
        end else if (wr_irq_mask) begin
            irq_mask_q <= pwdata[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO];
        end
    end

    // irq follows the status bits in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle

    always_comb begin
        rdata_d = `GPE_RST_PRDATA;
        case (reg_sel)
            gpe_pkg::GPE_REG_CONTROL: begin
                rdata_d[`GPE_BIT_POL_INVERT] = event_polarity_invert_q;
                rdata_d[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO] = port_event_divert_en_q;
            end
            gpe_pkg::GPE_REG_STATUS: begin
                rdata_d[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO] = port_event_active_q;
            end
            gpe_pkg::GPE_REG_IRQ_STATUS: begin
                rdata_d[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO] = irq_status_q;
            end
            gpe_pkg::GPE_REG_IRQ_MASK: begin
                rdata_d[`GPE_BIT_PORT_HI:`GPE_BIT_PORT_LO] = irq_mask_q;
            end
            gpe_pkg::GPE_REG_SOURCE: begin
                rdata_d[3*`GPE_SRC_W-1:0] = source_q;
            end
            gpe_pkg::GPE_REG_NONE: begin
                rdata_d = `GPE_RST_PRDATA;
            end
            default: begin
                rdata_d = `GPE_RST_PRDATA;
            end
        endcase
    end

    // captured in setup so prdata stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `GPE_RST_PRDATA;
        end else if (rd_setup && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    // error flag decided in setup, shown only in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (rd_setup) begin
            pslverr_q <= bad_addr | bad_write;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q & access_d;

endmodule

`default_nettype wire

// File: pkg/gpe_params.svh
`ifndef GPE_PARAMS_SVH
`define GPE_PARAMS_SVH

// apb address and data
`define GPE_ADDR_W 12
`define GPE_DATA_W 32

// register byte offsets
`define GPE_OFS_CONTROL 12'h450
`define GPE_OFS_STATUS 12'h454
`define GPE_OFS_IRQ_STATUS 12'h458
`define GPE_OFS_IRQ_MASK 12'h45C
`define GPE_OFS_SOURCE 12'h460

// event_control fields
`define GPE_BIT_POL_INVERT 0
`define GPE_BIT_PORT_LO 1
`define GPE_BIT_PORT_HI 3

// event_source fields: three bits per port, hot-plug at bit 0 of each group
`define GPE_SRC_W 3
`define GPE_SRC_BIT_HP 0
`define GPE_SRC_BIT_MSI 1
`define GPE_SRC_BIT_PME 2

// reset values
`define GPE_RST_CONTROL 4'h0
`define GPE_RST_STATUS 3'h0
`define GPE_RST_IRQ_STATUS 3'h0
`define GPE_RST_IRQ_MASK 3'h0
`define GPE_RST_PRDATA 32'h0000_0000
`define GPE_RST_POL_INVERT 1'h0
`define GPE_RST_DIVERT_EN 3'h0
`define GPE_RST_SOURCE 9'h000
// idle level of the shared event for the reset polarity
`define GPE_RST_EVENT 1'h1

// polarity encodings
`define GPE_POL_ACTIVE_LOW 1'h0
`define GPE_POL_ACTIVE_HIGH 1'h1

`endif

// File: pkg/gpe_pkg.sv
package gpe_pkg;

    // downstream ports 1 to 3
    typedef logic [3:1] gpe_port_vec_t;

    // decoded register selection, one-hot
    typedef enum logic [5:0] {
        GPE_REG_NONE = 6'b000001,
        GPE_REG_CONTROL = 6'b000010,
        GPE_REG_STATUS = 6'b000100,
        GPE_REG_IRQ_STATUS = 6'b001000,
        GPE_REG_IRQ_MASK = 6'b010000,
        GPE_REG_SOURCE = 6'b100000
    } gpe_reg_e;

endpackage

// File: src/gpe_port_event.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// one downstream port: steer its notifications either to the native
// mechanisms or onto the shared event
module gpe_port_event (
    input wire logic divert_en,
    input wire logic req_hotplug,
    input wire logic req_msi,
    input wire logic req_pme,
    output logic active,
    output logic pass_hotplug,
    output logic pass_msi,
    output logic pass_pme,
    output logic [2:0] source
);

    logic any_req;

    assign any_req = req_hotplug | req_msi | req_pme;

    // pending diverted notification of this port
    assign active = divert_en & any_req;

    // native paths closed while diverted
    assign pass_hotplug = req_hotplug & ~divert_en;
    assign pass_msi = req_msi & ~divert_en;
    assign pass_pme = req_pme & ~divert_en;

    // which kinds make up the diverted event
    assign source = divert_en ? {req_pme, req_msi, req_hotplug} : 3'h0;

endmodule

`default_nettype wire

// File: test/gpe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"
module gpe_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`GPE_ADDR_W-1:0] paddr,
    input wire logic [`GPE_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [`GPE_DATA_W-1:0] prdata,
    input wire logic [3:1] port_req_hotplug,
    input wire logic [3:1] port_req_msi,
    input wire logic [3:1] port_req_pme,
    input wire logic [3:1] port_pass_hotplug,
    input wire logic [3:1] port_pass_msi,
    input wire logic [3:1] port_pass_pme,
    input wire logic gpio7_alt_en,
    input wire logic gpio7_gen_out,
    input wire logic gpio7_gen_oe,
    input wire logic gpio7_out,
    input wire logic gpio7_oe,
    input wire logic shared_event_out
);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the control register
    logic pol_q;
    logic [3:1] en_q;
    logic [3:1] act;
    assign act = en_q & (port_req_hotplug | port_req_msi | port_req_pme);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= 1'h0;
            en_q <= 3'h0;
        end else if (psel && penable && pwrite && pstrb[0] && paddr == `GPE_OFS_CONTROL) begin
            pol_q <= pwdata[0];
            en_q <= pwdata[3:1];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence sts_rd;
        psel && !penable && !pwrite && paddr == `GPE_OFS_STATUS ##1 psel && penable;
    endsequence
    inv_level_a: assert property ($past(presetn) && $past(pol_q)
        |-> shared_event_out == |$past(act)) else $error("inverted level wrong");
    idle_level_a: assert property ($past(presetn) && $past(act) == 3'h0
        |-> shared_event_out == !$past(pol_q)) else $error("idle level wrong");
    divert_a: assert property ($past(presetn) |->
        {port_pass_hotplug, port_pass_msi, port_pass_pme} ==
        $past({port_req_hotplug, port_req_msi, port_req_pme} & {3{~en_q}}))
        else $error("pass vector wrong");
    alt_pin_a: assert property ($past(presetn) && $past(gpio7_alt_en)
        |-> gpio7_oe && gpio7_out == shared_event_out) else $error("alt pin wrong");
    gen_pin_a: assert property ($past(presetn) && !$past(gpio7_alt_en)
        |-> gpio7_out == $past(gpio7_gen_out) && gpio7_oe == $past(gpio7_gen_oe))
        else $error("gpio pin wrong");
    status_bits_a: assert property (sts_rd |-> prdata[3:1] == $past(act, 2))
        else $error("status wrong");
    status_en_a: assert property (sts_rd |-> (prdata[3:1] & ~$past(en_q, 2)) == 3'h0)
        else $error("status without enable");
    or_event_a: assert property ($past(presetn) && $past(act) != 3'h0
        |-> shared_event_out == $past(pol_q)) else $error("event level wrong");
endmodule
bind gpe_top gpe_top_chk gpe_top_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .port_req_hotplug, .port_req_msi, .port_req_pme,
    .port_pass_hotplug, .port_pass_msi, .port_pass_pme, .gpio7_alt_en, .gpio7_gen_out,
    .gpio7_gen_oe, .gpio7_out, .gpio7_oe, .shared_event_out);
`default_nettype wire

// File: test/gpe_sys_mon.sv
`timescale 1ns/1ps
`default_nettype none
// system logic watching gpio 7, pin pulled up while undriven
module gpe_sys_mon (
    input wire logic gpio7_out,
    input wire logic gpio7_oe,
    input wire logic pol_high,
    output logic evt_seen
);
    logic pin;
    assign pin = gpio7_oe ? gpio7_out : 1'h1;
    assign evt_seen = gpio7_oe && pin == pol_high;
endmodule
`default_nettype wire

// File: test/gpe_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"
module gpe_tb_top;
    typedef struct packed {
        logic [3:0] ctrl;
        logic [3:1] hp, msi, pme;
        logic alt, out;
        logic [3:1] sts;
    } gpe_row_s;
    gpe_row_s rows [7];
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic alt, gen_out, gen_oe, g_out, g_oe, sh_out, seen, pol_high;
    logic [`GPE_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [3:1] hp, msi, pme, p_hp, p_msi, p_pme;
    logic [8:0] src;
    int err_count, check_count;
    gpe_top gpe_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_req_hotplug(hp), .port_req_msi(msi),
        .port_req_pme(pme), .port_pass_hotplug(p_hp), .port_pass_msi(p_msi),
        .port_pass_pme(p_pme), .gpio7_alt_en(alt), .gpio7_gen_out(gen_out),
        .gpio7_gen_oe(gen_oe), .gpio7_out(g_out), .gpio7_oe(g_oe),
        .shared_event_out(sh_out), .irq(irq));
    gpe_sys_mon gpe_sys_mon_inst (.gpio7_out(g_out), .gpio7_oe(g_oe), .pol_high(pol_high),
        .evt_seen(seen));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [`GPE_ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, hp, msi, pme, alt} = '0;
        {pstrb, gen_out, gen_oe, pol_high, err_count, check_count} = {4'hF, 3'h4, 64'h0};
        rows = '{'{4'h0, 3'h1, 3'h0, 3'h0, 1'h1, 1'h1, 3'h0},
            '{4'h2, 3'h1, 3'h0, 3'h0, 1'h0, 1'h0, 3'h1}, '{4'h5, 3'h0, 3'h2, 3'h0, 1'h1, 1'h1, 3'h2},
            '{4'h9, 3'h1, 3'h0, 3'h4, 1'h1, 1'h1, 3'h4}, '{4'hF, 3'h3, 3'h4, 3'h0, 1'h1, 1'h1, 3'h7},
            '{4'h1, 3'h0, 3'h0, 3'h7, 1'h0, 1'h0, 3'h0}, '{4'hE, 3'h0, 3'h0, 3'h0, 1'h1, 1'h1, 3'h0}};
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            apb(1'h1, `GPE_OFS_CONTROL, {28'h0, rows[i].ctrl});
            {hp, msi, pme, alt} <= {rows[i].hp, rows[i].msi, rows[i].pme, rows[i].alt};
            pol_high <= rows[i].ctrl[0];
            repeat (2) @(posedge pclk);
            chk("shared", rows[i].out, sh_out);
            chk("gpio", rows[i].alt ? rows[i].out : gen_out, g_out);
            chk("oe", rows[i].alt ? 1'h1 : gen_oe, g_oe);
            chk("pass", {hp, msi, pme} & {3{~rows[i].ctrl[3:1]}}, {p_hp, p_msi, p_pme});
            chk("seen", rows[i].alt && rows[i].sts != 3'h0, seen);
            apb(1'h0, `GPE_OFS_STATUS, 32'h0);
            chk("status", rows[i].sts, rd[3:1]);
            for (int p = 1; p <= 3; p++) begin
                src[3*p-3 +: 3] = rows[i].ctrl[p]
                    ? {rows[i].pme[p], rows[i].msi[p], rows[i].hp[p]} : 3'h0;
            end
            apb(1'h0, `GPE_OFS_SOURCE, 32'h0);
            chk("source", {23'h0, src}, rd);
        end
        apb(1'h1, `GPE_OFS_IRQ_STATUS, 32'hE);
        apb(1'h1, `GPE_OFS_IRQ_MASK, 32'h2);
        chk("irq_idle", 1'h0, irq);
        apb(1'h1, `GPE_OFS_CONTROL, 32'h2);
        hp <= 3'h1;
        repeat (2) @(posedge pclk);
        chk("irq", 1'h1, irq);
        hp <= 3'h0;
        repeat (2) @(posedge pclk);
        chk("irq_sticky", 1'h1, irq);
        apb(1'h1, `GPE_OFS_IRQ_MASK, 32'h0);
        @(posedge pclk);
        chk("irq_masked", 1'h0, irq);
        apb(1'h1, `GPE_OFS_IRQ_STATUS, 32'h2);
        apb(1'h0, `GPE_OFS_IRQ_STATUS, 32'h0);
        chk("irq_clear", 32'h0, rd);
        apb(1'h1, `GPE_OFS_IRQ_MASK, 32'h2);
        @(posedge pclk);
        chk("irq_off", 1'h0, irq);
        fork
            apb(1'h1, `GPE_OFS_IRQ_STATUS, 32'h2);
            begin
                @(posedge pclk);
                hp <= 3'h1;
            end
        join
        apb(1'h0, `GPE_OFS_IRQ_STATUS, 32'h0);
        chk("set_wins", 32'h2, rd);
        chk("irq_set_wins", 1'h1, irq);
        hp <= 3'h0;
        apb(1'h1, `GPE_OFS_IRQ_STATUS, 32'h2);
        apb(1'h0, 12'h7F0, 32'h0);
        chk("unmapped_err", 1'h1, err);
        chk("unmapped_data", 32'h0, rd);
        apb(1'h1, `GPE_OFS_STATUS, 32'hE);
        chk("ro_err", 1'h1, err);
        apb(1'h0, `GPE_OFS_STATUS, 32'h0);
        chk("ro_keep", 32'h0, rd);
        apb(1'h1, `GPE_OFS_CONTROL, 32'hF);
        apb(1'h0, `GPE_OFS_CONTROL, 32'h0);
        chk("ctrl_rw", 32'hF, rd);
        pstrb <= 4'hE;
        apb(1'h1, `GPE_OFS_CONTROL, 32'h0);
        pstrb <= 4'hF;
        apb(1'h0, `GPE_OFS_CONTROL, 32'h0);
        chk("strb_keep", 32'hF, rd);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `GPE_OFS_CONTROL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        chk("idle_after_reset", 1'h1, sh_out);
        end_of_test;
    end
endmodule
`default_nettype wire
